//--- core/power_switch_retention_ctrl.sv
// Power switch controller with slow timers, retention supply and fast wake check.
`timescale 1ns/1ps
// Behaviour
// - Switch off all or selected domains
// - Slow 16.384 kHz oscillator in switch domain
// - Two slow-clocked timers can restore power
// - Timer zero spans 7.8125 ms to 1 s
// - Timer one spans 1 s to 16777216 s
// - Bandgap enable starts regulator, sets ready
// - Regulator keeps 8 kB array alive
// - Array sits at 0x20038000 to 0x20039FFF
// - Access while regulator-supplied raises fault
// - Array stores error check code per word
// - After reset array fed from core
// - On power-up return supply, then check CRC
// - CRC match jumps to stored entry
// - Switch reset defaults, output left enabled
// - Enabled wake pin falling edge restores power
module power_switch_retention_ctrl #(
  parameter int unsigned DOMAINS = 4,
  parameter int unsigned SLOW_DIV = pwr_sw_pkg::SLOW_DIV
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic switch_off_req,
  input wire logic [DOMAINS-1:0] domain_keep,
  input wire logic switch_on_req,
  input wire logic slow_osc_enable,
  input wire logic bandgap_enable,
  input wire logic retention_regulator_enable,
  input wire logic low_power_refresh,
  input wire logic isolate,
  input wire logic retention_supply_select,
  input wire logic timer0_enable,
  input wire logic [7:0] timer0_steps,
  input wire logic timer1_enable,
  input wire logic [24:0] timer1_steps,
  input wire logic wake_pin_enable,
  input wire logic switch_wake_pin_n,
  input wire logic boot_start,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [DOMAINS-1:0] domain_power_on,
  output logic slow_tick,
  output logic retention_regulator_on,
  output logic retention_regulator_ready,
  output logic low_power_refresh_on,
  output logic timer0_expired,
  output logic timer1_expired,
  output logic wake_pin_event,
  output logic sram_isolated,
  output logic sram_on_regulator,
  output logic mem_ack,
  output logic mem_fault,
  output logic [31:0] mem_rdata,
  output logic mem_ecc_err,
  output logic boot_done,
  output logic boot_fast,
  output logic [31:0] boot_entry
);
  if (DOMAINS < 1 || DOMAINS > 16)
  begin : g_bad_domains
    $error("DOMAINS must be 1 to 16");
  end
  // The divider counter is 17 bits wide, which bounds the ratio it can serve.
  if (SLOW_DIV < 2 || SLOW_DIV > 131072)
  begin : g_bad_div
    $error("SLOW_DIV must be 2 to 131072");
  end
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [DOMAINS-1:0] dom;
    logic [16:0] div;
    logic tick;
    logic reg_on;
    logic [3:0] settle;
    logic ready;
    logic lpr;
    logic [14:0] t0_pre;
    logic [7:0] t0_cnt;
    logic t0_run;
    logic t0_exp;
    logic [13:0] t1_pre;
    logic [24:0] t1_cnt;
    logic t1_run;
    logic t1_exp;
    logic pin_s1;
    logic pin_s2;
    logic pin_old;
    logic pin_ev;
    logic iso;
    logic sel;
    logic ack;
    logic fault;
    logic rd_pend;
    logic [31:0] rdata;
    logic ecc;
    pwr_sw_pkg::boot_state_t bst;
    logic [3:0] widx;
    logic [31:0] crc;
    logic bdone;
    logic bfast;
    logic [31:0] entry;
  } st_t;
  st_t q, d;
  logic in_range, ram_en, ram_we, ram_ecc;
  logic [10:0] ram_addr;
  logic [31:0] ram_rdata;
  logic wake;
  function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] w);
    logic [31:0] r;
    r = c ^ w;
    for (int i = 0; i < 32; i++) r = r[0] ? ((r >> 1) ^ pwr_sw_pkg::CRC_POLY) : (r >> 1);
    return r;
  endfunction
  assign in_range = mem_addr >= pwr_sw_pkg::RAM_BASE && mem_addr <= pwr_sw_pkg::RAM_LAST;
  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    d.pin_ev = 1'b0;
    d.ack = 1'b0;
    d.fault = 1'b0;
    d.rd_pend = 1'b0;
    ram_en = 1'b0;
    ram_we = 1'b0;
    ram_addr = mem_addr[12:2];
    // Slow oscillator runs only while enabled; all timers count its ticks.
    if (slow_osc_enable)
    begin
      if (q.div == 17'(SLOW_DIV - 1))
      begin
        d.div = '0;
        d.tick = 1'b1;
      end
      else d.div = q.div + 17'h00001;
    end
    // Bandgap enable also brings up the regulator and its ready flag.
    d.reg_on = bandgap_enable | retention_regulator_enable;
    d.lpr = low_power_refresh & d.reg_on;
    if (!d.reg_on)
    begin
      d.settle = '0;
      d.ready = 1'b0;
    end
    else if (q.tick && !q.ready)
    begin
      d.settle = q.settle + 4'h1;
      if (q.settle == pwr_sw_pkg::REG_SETTLE_TICKS - 4'h1) d.ready = 1'b1;
    end
    // Timer 0: steps of 128 slow ticks, clamped to its legal span.
    if (!(timer0_enable && bandgap_enable))
    begin
      d.t0_run = 1'b0;
      d.t0_exp = 1'b0;
      d.t0_pre = '0;
    end
    else if (!q.t0_run && !q.t0_exp)
    begin
      d.t0_run = 1'b1;
      d.t0_pre = '0;
      if (timer0_steps < pwr_sw_pkg::T0_MIN_STEPS) d.t0_cnt = pwr_sw_pkg::T0_MIN_STEPS;
      else if (timer0_steps > pwr_sw_pkg::T0_MAX_STEPS) d.t0_cnt = pwr_sw_pkg::T0_MAX_STEPS;
      else d.t0_cnt = timer0_steps;
    end
    else if (q.t0_run && q.tick)
    begin
      if (q.t0_pre == 15'(pwr_sw_pkg::T0_TICKS_PER_STEP - 1))
      begin
        d.t0_pre = '0;
        d.t0_cnt = q.t0_cnt - 8'h01;
        if (q.t0_cnt == 8'h01)
        begin
          d.t0_run = 1'b0;
          d.t0_exp = 1'b1;
        end
      end
      else d.t0_pre = q.t0_pre + 15'h0001;
    end
    // Timer 1: steps of one second.
    if (!(timer1_enable && bandgap_enable))
    begin
      d.t1_run = 1'b0;
      d.t1_exp = 1'b0;
      d.t1_pre = '0;
    end
    else if (!q.t1_run && !q.t1_exp)
    begin
      d.t1_run = 1'b1;
      d.t1_pre = '0;
      if (timer1_steps < pwr_sw_pkg::T1_MIN_STEPS) d.t1_cnt = pwr_sw_pkg::T1_MIN_STEPS;
      else if (timer1_steps > pwr_sw_pkg::T1_MAX_STEPS) d.t1_cnt = pwr_sw_pkg::T1_MAX_STEPS;
      else d.t1_cnt = timer1_steps;
    end
    else if (q.t1_run && q.tick)
    begin
      if (q.t1_pre == 14'(pwr_sw_pkg::T1_TICKS_PER_STEP - 1))
      begin
        d.t1_pre = '0;
        d.t1_cnt = q.t1_cnt - 25'h0000001;
        if (q.t1_cnt == 25'h0000001)
        begin
          d.t1_run = 1'b0;
          d.t1_exp = 1'b1;
        end
      end
      else d.t1_pre = q.t1_pre + 14'h0001;
    end
    // Wake pin is asynchronous; only the second stage feeds the edge detector.
    d.pin_s1 = switch_wake_pin_n;
    d.pin_s2 = q.pin_s1;
    d.pin_old = q.pin_s2;
    d.pin_ev = wake_pin_enable & q.pin_old & ~q.pin_s2;
    // Power-on sources win over an off request in the same cycle.
    wake = switch_on_req | q.pin_ev | (d.t0_exp & ~q.t0_exp) | (d.t1_exp & ~q.t1_exp);
    if (wake) d.dom = '1;
    else if (switch_off_req) d.dom = domain_keep;
    // Isolation must be set before selection and released after it.
    if (isolate) d.iso = 1'b1;
    else if (!q.sel) d.iso = 1'b0;
    if (retention_supply_select && q.iso && q.ready) d.sel = 1'b1;
    else if (!retention_supply_select) d.sel = 1'b0;
    // Boot sequencer: return supply, recompute CRC, compare, fetch entry.
    case (q.bst)
      pwr_sw_pkg::BOOT_IDLE:
      begin
        if (boot_start)
        begin
          d.bst = pwr_sw_pkg::BOOT_SUPPLY;
          d.bdone = 1'b0;
          d.bfast = 1'b0;
        end
      end
      pwr_sw_pkg::BOOT_SUPPLY:
      begin
        d.sel = 1'b0;
        if (!q.sel)
        begin
          d.iso = 1'b0;
          d.widx = '0;
          d.crc = pwr_sw_pkg::CRC_INIT;
          if (!q.iso) d.bst = pwr_sw_pkg::BOOT_CRC;
        end
      end
      pwr_sw_pkg::BOOT_CRC:
      begin
        ram_en = 1'b1;
        ram_addr = (q.widx == 4'(pwr_sw_pkg::IMG_WORDS)) ? pwr_sw_pkg::CRC_ADDR[12:2] : 11'(q.widx);
        if (q.rd_pend)
        begin
          d.crc = crc_word(q.crc, ram_rdata);
          d.widx = q.widx + 4'h1;
          if (q.widx == 4'(pwr_sw_pkg::IMG_WORDS - 1)) d.bst = pwr_sw_pkg::BOOT_CMP;
        end
        else d.rd_pend = 1'b1;
      end
      pwr_sw_pkg::BOOT_CMP:
      begin
        ram_en = 1'b1;
        ram_addr = pwr_sw_pkg::CRC_ADDR[12:2];
        if (q.rd_pend)
        begin
          if ((~q.crc) == ram_rdata) d.bst = pwr_sw_pkg::BOOT_ENTRY;
          else d.bst = pwr_sw_pkg::BOOT_DONE;
        end
        else d.rd_pend = 1'b1;
      end
      pwr_sw_pkg::BOOT_ENTRY:
      begin
        ram_en = 1'b1;
        ram_addr = pwr_sw_pkg::ENTRY_ADDR[12:2];
        if (q.rd_pend)
        begin
          d.entry = ram_rdata;
          d.bfast = 1'b1;
          d.bst = pwr_sw_pkg::BOOT_DONE;
        end
        else d.rd_pend = 1'b1;
      end
      pwr_sw_pkg::BOOT_DONE:
      begin
        d.bdone = 1'b1;
        d.bst = pwr_sw_pkg::BOOT_IDLE;
      end
      default: d.bst = pwr_sw_pkg::BOOT_IDLE;
    endcase
    // Software port; refused with a fault while isolated or regulator-fed.
    if (q.bst == pwr_sw_pkg::BOOT_IDLE && mem_req && in_range)
    begin
      if (q.sel || q.iso) d.fault = 1'b1;
      else
      begin
        ram_en = 1'b1;
        ram_we = mem_we;
        d.rd_pend = ~mem_we;
        d.ack = mem_we;
      end
    end
    if (q.bst == pwr_sw_pkg::BOOT_IDLE && q.rd_pend)
    begin
      d.ack = 1'b1;
      d.rdata = ram_rdata;
      d.ecc = ram_ecc;
    end
  end
  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
      q.dom <= {DOMAINS{pwr_sw_pkg::RST_SWITCH_ON}};
      q.pin_s1 <= 1'b1;
      q.pin_s2 <= 1'b1;
      q.pin_old <= 1'b1;
      q.sel <= 1'b0;
      q.bst <= pwr_sw_pkg::BOOT_IDLE;
    end
    else q <= d;
  end
  ret_sram #(
    .WORDS(pwr_sw_pkg::RAM_WORDS)
  ) i_ret_sram (
    .clk_sys(clk_sys),
    .en(ram_en),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(mem_wdata),
    .rdata_q(ram_rdata),
    .ecc_err_q(ram_ecc)
  );
  assign domain_power_on = q.dom;
  assign slow_tick = q.tick;
  assign retention_regulator_on = q.reg_on;
  assign retention_regulator_ready = q.ready;
  assign low_power_refresh_on = q.lpr;
  assign timer0_expired = q.t0_exp;
  assign timer1_expired = q.t1_exp;
  assign wake_pin_event = q.pin_ev;
  assign sram_isolated = q.iso;
  assign sram_on_regulator = q.sel;
  assign mem_ack = q.ack;
  assign mem_fault = q.fault;
  assign mem_rdata = q.rdata;
  assign mem_ecc_err = q.ecc;
  assign boot_done = q.bdone;
  assign boot_fast = q.bfast;
  assign boot_entry = q.entry;
  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence pin_fall_s;
    wake_pin_enable && $past(q.pin_s2) && !q.pin_s2;
  endsequence
  pin_wake_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pin_fall_s |=> ##1 (domain_power_on == '1)) else $error("wake pin did not power on");
  fault_iso_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (mem_req && in_range && (q.sel || q.iso) && q.bst == pwr_sw_pkg::BOOT_IDLE)
    |=> mem_fault && !mem_ack) else $error("access not faulted");
  sel_needs_iso_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(sram_on_regulator) |-> $past(sram_isolated)) else $error("selected without isolation");
  iso_held_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $fell(sram_isolated) |-> !$past(sram_on_regulator)) else $error("isolation dropped early");
  bg_reg_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    bandgap_enable |=> retention_regulator_on) else $error("regulator not on with bandgap");
  t0_once_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    timer0_expired && timer0_enable && bandgap_enable |=> timer0_expired)
    else $error("timer0 expiry not held");
  t_stop_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !timer1_enable |=> !timer1_expired && !q.t1_run) else $error("timer1 runs disabled");
  t0_span_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    q.t0_run |-> q.t0_cnt <= pwr_sw_pkg::T0_MAX_STEPS) else $error("timer0 out of span");
  boot_supply_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    q.bst == pwr_sw_pkg::BOOT_CRC |-> !sram_on_regulator) else $error("CRC on regulator supply");
  fast_entry_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(boot_fast) |-> ##1 boot_done) else $error("fast boot not finished");
endmodule

//--- pkg/pwr_sw_pkg.sv
// Constants and types shared by the power switch retention controller.
package pwr_sw_pkg;
  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SLOW_OSC_HZ = 16_384;
  // The slow oscillator tick is a divided enable; the ratio rounds down.
  localparam int unsigned SLOW_DIV = CLK_HZ / SLOW_OSC_HZ;
  // Timer 0 counts 1/128 s steps: 7.8125 ms minimum, 1 s maximum.
  localparam int unsigned T0_TICKS_PER_STEP = 128;
  localparam logic [7:0] T0_MIN_STEPS = 8'h01;
  localparam logic [7:0] T0_MAX_STEPS = 8'h80;
  // Timer 1 counts whole seconds: 1 s minimum, 16,777,216 s maximum.
  localparam int unsigned T1_TICKS_PER_STEP = 16_384;
  localparam logic [24:0] T1_MIN_STEPS = 25'h0000001;
  localparam logic [24:0] T1_MAX_STEPS = 25'h1000000;
  // Regulator settling time in slow ticks before ready is shown.
  localparam logic [3:0] REG_SETTLE_TICKS = 4'h4;
  // ****************************************************************
  // Retention SRAM map
  // ****************************************************************
  localparam logic [31:0] RAM_BASE = 32'h2003_8000;
  localparam logic [31:0] RAM_LAST = 32'h2003_9FFF;
  localparam logic [31:0] CRC_ADDR = 32'h2003_9FF8;
  localparam logic [31:0] ENTRY_ADDR = 32'h2003_9FFC;
  localparam int unsigned RAM_WORDS = 2048;
  localparam int unsigned IMG_WORDS = 12;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_SWITCH_ON = 1'b1;
  localparam logic RST_SLOW_OSC_EN = 1'b1;
  typedef enum logic [2:0] {
    BOOT_IDLE = 3'b000,
    BOOT_SUPPLY = 3'b001,
    BOOT_CRC = 3'b010,
    BOOT_CMP = 3'b011,
    BOOT_ENTRY = 3'b100,
    BOOT_DONE = 3'b101
  } boot_state_t;
endpackage

//--- core/ret_sram.sv
// Retention SRAM with registered read data and a parity-style check code.
`timescale 1ns/1ps
module ret_sram #(
  parameter int unsigned WORDS = 2048
) (
  input wire logic clk_sys,
  input wire logic en,
  input wire logic we,
  input wire logic [10:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata_q,
  output logic ecc_err_q
);
  // The address width is fixed at 11 bits, so only the full array depth is served.
  if (WORDS != 2048)
  begin : g_bad_words
    $error("ret_sram supports 2048 words only");
  end
  logic [38:0] mem [WORDS];
  // A 7-bit check code per word; a stored code mismatch flags an error.
  function automatic logic [6:0] code(input logic [31:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 0; i < 32; i++) c[i % 7] = c[i % 7] ^ d[i];
    return c;
  endfunction
  always_ff @(posedge clk_sys)
  begin
    if (en && we) mem[addr] <= {code(wdata), wdata};
    if (en && !we)
    begin
      rdata_q <= mem[addr][31:0];
      ecc_err_q <= (code(mem[addr][31:0]) != mem[addr][38:32]);
    end
  end
endmodule

//--- tb/power_switch_retention_ctrl_test.sv
// Self-checking testbench for the power switch retention controller.
`timescale 1ns/1ps
module power_switch_retention_ctrl_test;
  // ****************************************************************
  // Clock, reset and stimulus signals
  // ****************************************************************
  localparam int unsigned DIV = 4;
  localparam int LIMIT = 90000;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic switch_off_req = 1'b0, switch_on_req = 1'b0, slow_osc_enable = 1'b0;
  logic [3:0] domain_keep = 4'h0;
  logic bandgap_enable = 1'b0, retention_regulator_enable = 1'b0, low_power_refresh = 1'b0;
  logic isolate = 1'b0, retention_supply_select = 1'b0, timer0_enable = 1'b0;
  logic timer1_enable = 1'b0, wake_pin_enable = 1'b0, switch_wake_pin_n = 1'b1;
  logic boot_start = 1'b0, mem_req = 1'b0, mem_we = 1'b0;
  logic [7:0] timer0_steps = 8'h00;
  logic [24:0] timer1_steps = 25'h0000000;
  logic [31:0] mem_addr = 32'h0000_0000, mem_wdata = 32'h0000_0000;
  logic [3:0] domain_power_on;
  logic slow_tick, retention_regulator_on, retention_regulator_ready, low_power_refresh_on;
  logic timer0_expired, timer1_expired, wake_pin_event, sram_isolated, sram_on_regulator;
  logic mem_ack, mem_fault, mem_ecc_err, boot_done, boot_fast;
  logic [31:0] mem_rdata, boot_entry;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] img [12];
  always #4 clk_sys = ~clk_sys;
  // The slow tick is shortened so that a one-second count stays within the run.
  power_switch_retention_ctrl #(.DOMAINS(4), .SLOW_DIV(DIV)) i_power_switch_retention_ctrl (
    .clk_sys(clk_sys), .arst_n(arst_n), .switch_off_req(switch_off_req),
    .domain_keep(domain_keep), .switch_on_req(switch_on_req),
    .slow_osc_enable(slow_osc_enable), .bandgap_enable(bandgap_enable),
    .retention_regulator_enable(retention_regulator_enable),
    .low_power_refresh(low_power_refresh), .isolate(isolate),
    .retention_supply_select(retention_supply_select), .timer0_enable(timer0_enable),
    .timer0_steps(timer0_steps), .timer1_enable(timer1_enable), .timer1_steps(timer1_steps),
    .wake_pin_enable(wake_pin_enable), .switch_wake_pin_n(switch_wake_pin_n),
    .boot_start(boot_start), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .domain_power_on(domain_power_on), .slow_tick(slow_tick),
    .retention_regulator_on(retention_regulator_on),
    .retention_regulator_ready(retention_regulator_ready),
    .low_power_refresh_on(low_power_refresh_on), .timer0_expired(timer0_expired),
    .timer1_expired(timer1_expired), .wake_pin_event(wake_pin_event),
    .sram_isolated(sram_isolated), .sram_on_regulator(sram_on_regulator),
    .mem_ack(mem_ack), .mem_fault(mem_fault), .mem_rdata(mem_rdata),
    .mem_ecc_err(mem_ecc_err), .boot_done(boot_done), .boot_fast(boot_fast),
    .boot_entry(boot_entry)
  );
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Compared %0d values, %0d mismatches", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One request, held for exactly the edge that takes it; replies are pulses.
  task automatic mem_op(input logic we, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic ack, output logic flt);
    @(posedge clk_sys);
    mem_req <= 1'b1;
    mem_we <= we;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge clk_sys);
    mem_req <= 1'b0;
    ack = 1'b0;
    flt = 1'b0;
    repeat (4)
    begin
      @(negedge clk_sys);
      if (mem_ack === 1'b1) ack = 1'b1;
      if (mem_fault === 1'b1) flt = 1'b1;
    end
    rd = mem_rdata;
  endtask
  // Reflected CRC over the bytes of the image, lowest byte of each word first.
  function automatic logic [31:0] crc_img();
    logic [31:0] c;
    c = pwr_sw_pkg::CRC_INIT;
    for (int w = 0; w < 12; w++)
      for (int b = 0; b < 4; b++)
      begin
        c = c ^ {24'h000000, img[w][8*b +: 8]};
        for (int k = 0; k < 8; k++)
          c = c[0] ? ((c >> 1) ^ pwr_sw_pkg::CRC_POLY) : (c >> 1);
      end
    return ~c;
  endfunction
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_and_domains();
    int n;
    check(domain_power_on, 32'hF);
    check({sram_isolated, sram_on_regulator, retention_regulator_on}, 32'h0);
    @(posedge clk_sys);
    slow_osc_enable <= 1'b1;
    for (n = 0; n < 20 && slow_tick !== 1'b1; n++) @(negedge clk_sys);
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end while (slow_tick !== 1'b1 && n < 20);
    check(n, DIV);
    @(posedge clk_sys);
    domain_keep <= 4'h5;
    switch_off_req <= 1'b1;
    @(posedge clk_sys);
    switch_off_req <= 1'b0;
    repeat (2) @(negedge clk_sys);
    check(domain_power_on, 32'h5);
    @(posedge clk_sys);
    switch_on_req <= 1'b1;
    @(posedge clk_sys);
    switch_on_req <= 1'b0;
    repeat (2) @(negedge clk_sys);
    check(domain_power_on, 32'hF);
  endtask
  task automatic t_regulator();
    int n;
    @(posedge clk_sys);
    bandgap_enable <= 1'b1;
    low_power_refresh <= 1'b1;
    for (n = 0; n < 40 && retention_regulator_ready !== 1'b1; n++) @(negedge clk_sys);
    check(retention_regulator_on, 32'h1);
    check(retention_regulator_ready, 32'h1);
    @(posedge clk_sys);
    retention_regulator_enable <= 1'b1;
    repeat (2) @(negedge clk_sys);
    check(low_power_refresh_on, 32'h1);
  endtask
  task automatic t_memory_handover();
    logic [31:0] rd;
    logic ack, flt;
    for (int i = 0; i < 12; i++)
    begin
      img[i] = 32'h0101_0101 * (i + 1);
      mem_op(1'b1, pwr_sw_pkg::RAM_BASE + 4 * i, img[i], rd, ack, flt);
    end
    mem_op(1'b1, pwr_sw_pkg::CRC_ADDR, crc_img(), rd, ack, flt);
    mem_op(1'b1, pwr_sw_pkg::ENTRY_ADDR, 32'h0000_4A31, rd, ack, flt);
    check({ack, flt}, 32'h2);
    mem_op(1'b0, pwr_sw_pkg::RAM_BASE + 8, 32'h0, rd, ack, flt);
    check({ack, flt, mem_ecc_err}, 32'h4);
    check(rd, img[2]);
    mem_op(1'b1, pwr_sw_pkg::RAM_LAST + 1, 32'h0, rd, ack, flt);
    check({ack, flt}, 32'h0);
    mem_op(1'b0, pwr_sw_pkg::RAM_BASE - 4, 32'h0, rd, ack, flt);
    check({ack, flt}, 32'h0);
    @(posedge clk_sys);
    isolate <= 1'b1;
    repeat (3) @(posedge clk_sys);
    retention_supply_select <= 1'b1;
    repeat (3) @(negedge clk_sys);
    check({sram_isolated, sram_on_regulator}, 32'h3);
    mem_op(1'b0, pwr_sw_pkg::RAM_BASE, 32'h0, rd, ack, flt);
    check({ack, flt}, 32'h1);
    mem_op(1'b1, pwr_sw_pkg::RAM_LAST - 3, 32'h0, rd, ack, flt);
    check({ack, flt}, 32'h1);
  endtask
  task automatic t_boot(input logic match);
    int n;
    @(posedge clk_sys);
    retention_supply_select <= 1'b0;
    boot_start <= 1'b1;
    @(posedge clk_sys);
    isolate <= 1'b0;
    boot_start <= 1'b0;
    // Let the start edge clear the previous boot result before polling it.
    @(negedge clk_sys);
    for (n = 0; n < 300 && boot_done !== 1'b1; n++) @(negedge clk_sys);
    check(boot_done, 32'h1);
    check({sram_isolated, sram_on_regulator}, 32'h0);
    check(boot_fast, {31'h0, match});
    if (match)
      check(boot_entry, 32'h0000_4A31);
  endtask
  task automatic t_bad_crc();
    logic [31:0] rd;
    logic ack, flt;
    mem_op(1'b1, pwr_sw_pkg::CRC_ADDR, ~crc_img(), rd, ack, flt);
    t_boot(1'b0);
  endtask
  task automatic t_timer(input logic sel);
    int n, exp;
    @(posedge clk_sys);
    domain_keep <= 4'h0;
    switch_off_req <= 1'b1;
    @(posedge clk_sys);
    switch_off_req <= 1'b0;
    timer0_steps <= 8'h01;
    timer1_steps <= 25'h0000001;
    timer0_enable <= !sel;
    timer1_enable <= sel;
    exp = sel ? 16384 * DIV : 128 * DIV;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end while ((sel ? timer1_expired : timer0_expired) !== 1'b1 && n < exp + 40);
    check(n >= exp - DIV && n <= exp + DIV + 4, 32'h1);
    repeat (2) @(negedge clk_sys);
    check(domain_power_on, 32'hF);
    @(posedge clk_sys);
    timer0_enable <= 1'b0;
    timer1_enable <= 1'b0;
    repeat (3) @(negedge clk_sys);
    check({timer1_expired, timer0_expired}, 32'h0);
  endtask
  task automatic t_wake_pin();
    int n;
    @(posedge clk_sys);
    domain_keep <= 4'h2;
    switch_off_req <= 1'b1;
    wake_pin_enable <= 1'b1;
    @(posedge clk_sys);
    switch_off_req <= 1'b0;
    repeat (3) @(negedge clk_sys);
    check(domain_power_on, 32'h2);
    @(posedge clk_sys);
    switch_wake_pin_n <= 1'b0;
    for (n = 0; n < 8 && wake_pin_event !== 1'b1; n++) @(negedge clk_sys);
    check(wake_pin_event, 32'h1);
    repeat (2) @(negedge clk_sys);
    check(domain_power_on, 32'hF);
    @(posedge clk_sys);
    switch_wake_pin_n <= 1'b1;
  endtask
  // ****************************************************************
  // Main sequence and hang guard
  // ****************************************************************
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      bad_count++;
      $display("MISMATCH at %0t: run did not finish in time", $time);
      print_verdict();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(negedge clk_sys);
    t_reset_and_domains();
    t_regulator();
    t_memory_handover();
    t_boot(1'b1);
    t_bad_crc();
    t_timer(1'b0);
    t_timer(1'b1);
    t_wake_pin();
    print_verdict();
  end
endmodule
